// >>> irq_cfg.svh
// constants for the interrupt control and context save block
// assumes one core clock at 250 MHz and an AXI4-Lite register bus
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH
`define ADDR_W 8
// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_PERIPH_EN 8'h04
`define OFS_EDGE_SEL 8'h08
`define OFS_SHADOW_BASE 8'h20
`define OFS_SHADOW_LAST 8'h3c
// control register fields
`define BIT_GLOBAL_EN 7
`define BIT_PERIPH_EN 6
`define BIT_T0_EN 5
`define BIT_EXT_EN 4
`define BIT_PC_EN 3
`define BIT_T0_FLAG 2
`define BIT_EXT_FLAG 1
`define BIT_PC_SUM 0
`define CONTROL_RESET 8'h00
`define PERIPH_EN_RESET 8'h00
// status bits kept in shadow: watchdog expiry and sleep entry are not
`define STATUS_SAVE_MASK 8'h07
`define VECTOR_PC 15'h0004
// timing
`define CLK_NS 4
`define TCY_NS 16
`define ENTRY_TCY 3
`define ENTRY_CLKS ((`ENTRY_TCY * `TCY_NS) / `CLK_NS)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> irq_pkg.sv
// types for the interrupt control and context save block
// assumes irq_cfg.svh supplies the constants
package irq_pkg;
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] status;
    logic [7:0] bank_select;
    logic [7:0] ptr0_lo;
    logic [7:0] ptr0_hi;
    logic [7:0] ptr1_lo;
    logic [7:0] ptr1_hi;
    logic [7:0] pc_upper_latch;
  } context_type;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_HANDLER
  } seq_state_type;
endpackage

// >>> mcu_interrupt_control_context_save.sv
// interrupt control, external edge pin, context shadow save/restore
// assumes a core sequencer on the same clock and an AXI4-Lite master
`timescale 1ns/1ns
`include "irq_cfg.svh"

module mcu_interrupt_control_context_save (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [`ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic ext_edge_pin_i,
  input wire logic timer0_ovf_i,
  input wire logic [7:0] pin_change_flags_i,
  input wire logic [7:0] periph_flags_i,
  input wire logic [14:0] pc_i,
  input wire irq_pkg::context_type live_ctx_i,
  input wire logic return_from_handler_i,
  output logic irq_enter_o,
  output logic [14:0] push_pc_o,
  output logic [14:0] vector_pc_o,
  output logic handler_exit_o,
  output irq_pkg::context_type restore_ctx_o,
  output logic in_handler_o
);

  logic [7:0] control;
  logic [7:0] periph_enable_one;
  logic edge_polarity_sel;
  logic [7:0] shadow [0:7];
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic edge_hit;
  logic pending;
  logic wr_go;
  logic [`ADDR_W-1:0] wr_addr;
  logic wr_shadow;
  logic rd_go;
  logic [3:0] wait_cnt;
  logic [3:0] wait_len;
  irq_pkg::seq_state_type state;
  irq_pkg::seq_state_type next_state;
  logic take;

  function automatic logic in_shadow(input logic [`ADDR_W-1:0] a);
    in_shadow = (a >= `OFS_SHADOW_BASE) && (a <= `OFS_SHADOW_LAST) &&
                (a[1:0] == 2'h0);
  endfunction

  function automatic logic mapped(input logic [`ADDR_W-1:0] a);
    mapped = (a == `OFS_CONTROL) || (a == `OFS_PERIPH_EN) ||
             (a == `OFS_EDGE_SEL) || in_shadow(a);
  endfunction

  // ---- external pin: two flops before any logic reads it
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= ext_edge_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign edge_hit = edge_polarity_sel ? (pin_s2 & ~pin_s3)
                                      : (~pin_s2 & pin_s3);

  // ---- bus write channel: both address and data wanted before acting
  assign wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_awready_o &&
                 !s_axi_bvalid_o;
  assign wr_addr = s_axi_awaddr_i;
  assign wr_shadow = s_axi_awready_o && in_shadow(wr_addr) &&
                     s_axi_wstrb_i[0];

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `RESP_OKAY;
    end else begin
      s_axi_awready_o <= wr_go;
      s_axi_wready_o <= wr_go;
      if (s_axi_awready_o) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ---- control register; hardware set beats a software clear
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      control <= `CONTROL_RESET;
    end else begin
      if (s_axi_awready_o && wr_addr == `OFS_CONTROL && s_axi_wstrb_i[0])
      begin
        control[7:1] <= s_axi_wdata_i[7:1];
      end
      if (take) begin
        control[`BIT_GLOBAL_EN] <= 1'b0;
      end else if (state == irq_pkg::ST_HANDLER && return_from_handler_i)
      begin
        control[`BIT_GLOBAL_EN] <= 1'b1;
      end
      if (edge_hit) begin
        control[`BIT_EXT_FLAG] <= 1'b1;
      end
      if (timer0_ovf_i) begin
        control[`BIT_T0_FLAG] <= 1'b1;
      end
      control[`BIT_PC_SUM] <= |pin_change_flags_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      periph_enable_one <= `PERIPH_EN_RESET;
      edge_polarity_sel <= 1'b0;
    end else if (s_axi_awready_o && s_axi_wstrb_i[0]) begin
      if (wr_addr == `OFS_PERIPH_EN) begin
        periph_enable_one <= s_axi_wdata_i[7:0];
      end
      if (wr_addr == `OFS_EDGE_SEL) begin
        edge_polarity_sel <= s_axi_wdata_i[0];
      end
    end
  end

  // ---- pending and acceptance
  assign pending =
    (control[`BIT_EXT_FLAG] & control[`BIT_EXT_EN]) |
    (control[`BIT_T0_FLAG] & control[`BIT_T0_EN]) |
    (control[`BIT_PC_SUM] & control[`BIT_PC_EN]) |
    (control[`BIT_PERIPH_EN] &
     (|(periph_enable_one & periph_flags_i)));

  // a short wait models the instruction-cycle latency of the core
  assign take = (state == irq_pkg::ST_WAIT) && control[`BIT_GLOBAL_EN] &&
                pending && (wait_cnt == 4'h0);

  always_comb begin
    next_state = state;
    case (state)
      irq_pkg::ST_IDLE: begin
        if (control[`BIT_GLOBAL_EN] && pending) begin
          next_state = irq_pkg::ST_WAIT;
        end
      end
      irq_pkg::ST_WAIT: begin
        if (take) begin
          next_state = irq_pkg::ST_HANDLER;
        end else if (!(control[`BIT_GLOBAL_EN] && pending)) begin
          next_state = irq_pkg::ST_IDLE;
        end
      end
      irq_pkg::ST_HANDLER: begin
        if (return_from_handler_i) begin
          next_state = irq_pkg::ST_IDLE;
        end
      end
      default: next_state = irq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= irq_pkg::ST_IDLE;
      wait_cnt <= 4'h0;
    end else begin
      state <= next_state;
      if (state != irq_pkg::ST_WAIT) begin
        wait_cnt <= 4'(`ENTRY_CLKS - 2);
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end

  // cycles spent waiting, kept apart from the entry counter for checking
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_len <= 4'h0;
    end else if (state == irq_pkg::ST_WAIT) begin
      wait_len <= wait_len + 4'h1;
    end else begin
      wait_len <= 4'h0;
    end
  end

  // ---- core sequencer strobes
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_enter_o <= 1'b0;
      push_pc_o <= 15'h0000;
      vector_pc_o <= `VECTOR_PC;
      handler_exit_o <= 1'b0;
      in_handler_o <= 1'b0;
    end else begin
      irq_enter_o <= take;
      if (take) begin
        push_pc_o <= pc_i;
      end
      vector_pc_o <= `VECTOR_PC;
      handler_exit_o <= (state == irq_pkg::ST_HANDLER) &&
                        return_from_handler_i;
      in_handler_o <= (next_state == irq_pkg::ST_HANDLER);
    end
  end

  // ---- shadow bank: entry capture wins over a same-cycle bus write
  generate
    for (genvar i = 0; i < 8; i++) begin : g_shadow
      localparam int FIELD = 7 - i;
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          shadow[i] <= 8'h00;
        end else if (take) begin
          shadow[i] <= (i == 1) ?
            (live_ctx_i[FIELD*8 +: 8] & `STATUS_SAVE_MASK) :
            live_ctx_i[FIELD*8 +: 8];
        end else if (wr_shadow && wr_addr[4:2] == 3'(i)) begin
          shadow[i] <= s_axi_wdata_i[7:0];
        end
      end
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          restore_ctx_o[FIELD*8 +: 8] <= 8'h00;
        end else if (state == irq_pkg::ST_HANDLER && return_from_handler_i)
        begin
          restore_ctx_o[FIELD*8 +: 8] <= shadow[i];
        end
      end
    end
  endgenerate

  // ---- bus read channel
  assign rd_go = s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `RESP_OKAY;
    end else begin
      s_axi_arready_o <= rd_go;
      if (s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= mapped(s_axi_araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
        if (s_axi_araddr_i == `OFS_CONTROL) begin
          s_axi_rdata_o <= {24'h000000, control};
        end else if (s_axi_araddr_i == `OFS_PERIPH_EN) begin
          s_axi_rdata_o <= {24'h000000, periph_enable_one};
        end else if (s_axi_araddr_i == `OFS_EDGE_SEL) begin
          s_axi_rdata_o <= {31'h00000000, edge_polarity_sel};
        end else if (in_shadow(s_axi_araddr_i)) begin
          s_axi_rdata_o <= {24'h000000, shadow[s_axi_araddr_i[4:2]]};
        end else begin
          s_axi_rdata_o <= 32'h0000_0000;
        end
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ---- checks
  chk_edge_sets_flag: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    edge_hit |=> control[`BIT_EXT_FLAG])
    else $error("edge did not set the external edge flag");

  chk_entry_clears_gie: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    take |=> irq_enter_o && !control[`BIT_GLOBAL_EN] &&
             vector_pc_o == `VECTOR_PC && push_pc_o == $past(pc_i))
    else $error("entry did not clear enable or push pc");

  chk_status_masked: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    take |=> shadow[1] == ($past(live_ctx_i.status) & `STATUS_SAVE_MASK) &&
             shadow[0] == $past(live_ctx_i.acc))
    else $error("context not captured on entry");

  chk_restore_value: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (state == irq_pkg::ST_HANDLER && return_from_handler_i) |=>
      handler_exit_o && restore_ctx_o.acc == $past(shadow[0]) &&
      restore_ctx_o.pc_upper_latch == $past(shadow[7]))
    else $error("restore did not use the shadow copies");

  chk_return_sets_gie: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    handler_exit_o |-> control[`BIT_GLOBAL_EN] && !in_handler_o)
    else $error("return did not set the global enable");

  chk_entry_latency: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (state == irq_pkg::ST_WAIT && control[`BIT_GLOBAL_EN] && pending &&
     wait_len == 4'(`ENTRY_CLKS - 2)) |=> irq_enter_o)
    else $error("entry latency out of range");

  chk_entry_not_early: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    take |-> wait_len == 4'(`ENTRY_CLKS - 2))
    else $error("entry taken before the wait ran out");

  chk_no_entry_gated: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !control[`BIT_GLOBAL_EN] |=> !irq_enter_o)
    else $error("entry while global enable was clear");

  chk_summary_flag: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ##1 control[`BIT_PC_SUM] == $past(|pin_change_flags_i))
    else $error("pin change summary wrong");

  chk_shadow_write: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (wr_shadow && !take && wr_addr[4:2] == 3'h0) |=>
      shadow[0] == $past(s_axi_wdata_i[7:0]))
    else $error("shadow write lost");

endmodule

// >>> core_seq_model.sv
// core sequencer stand-in: pc, live context, delayed handler return
// assumes the block's clock and reset, and irq_pkg compiled first
`timescale 1ns/1ns
module core_seq_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic enter_i,
  input wire logic exit_i,
  input wire irq_pkg::context_type restore_ctx_i,
  input wire logic [7:0] delay_i,
  output logic [14:0] pc_o,
  output irq_pkg::context_type live_ctx_o,
  output logic ret_o
);
  logic [7:0] count;
  logic busy;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_o <= 15'h0123;
      live_ctx_o <= 64'h11ff_3344_5566_7788;
      ret_o <= 1'b0;
      busy <= 1'b0;
      count <= 8'h00;
    end else begin
      ret_o <= 1'b0;
      if (enter_i) begin
        // handler scribbles over every live register
        live_ctx_o <= ~live_ctx_o;
        pc_o <= 15'h0004;
        busy <= 1'b1;
        count <= delay_i;
      end else if (busy && count == 8'h00) begin
        ret_o <= 1'b1;
        busy <= 1'b0;
      end else if (busy) begin
        count <= count - 8'h01;
      end
      if (exit_i) begin
        live_ctx_o <= restore_ctx_i;
        pc_o <= 15'h0123;
      end
    end
  end
endmodule

// >>> mcu_interrupt_control_context_save_tb.sv
// self-checking bench: registers, edge pin, flags, entry and return
// assumes irq_cfg.svh, irq_pkg and core_seq_model compiled first
`timescale 1ns/1ns
`include "irq_cfg.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t got %h exp %h", $time, g, e); end end
module mcu_interrupt_control_context_save_tb;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0] r;
  } row_type;
  row_type rows [5] = '{
    '{`OFS_PERIPH_EN, 32'ha5, 32'ha5, `RESP_OKAY},
    '{`OFS_PERIPH_EN, 32'h5a, 32'h5a, `RESP_OKAY},
    '{`OFS_CONTROL, 32'h38, 32'h38, `RESP_OKAY},
    '{`OFS_SHADOW_LAST, 32'hc3, 32'hc3, `RESP_OKAY},
    '{8'h10, 32'hff, 32'h0, `RESP_SLVERR}};
  // polarity select, pin level, expected flag
  logic [2:0] edges [4] = '{3'b111, 3'b100, 3'b010, 3'b001};
  logic [31:0] ctl [2] = '{32'h80, 32'h40};
  logic clk = 1'b0, rstn = 1'b0, pin = 1'b0, t0 = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pcf = 8'h00, pf = 8'h00;
  logic [7:0] dly = 8'h3c;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic awready, wready, bvalid, arready, rvalid, ret, enter, hx, in_h;
  logic [1:0] bresp, rresp, resp;
  logic [14:0] pc, push_pc, vec;
  irq_pkg::context_type live, rest;
  int num_errors = 0, checked = 0, lat;
  logic [7:0] seen;

  mcu_interrupt_control_context_save u_dut (
    .ref_clk_i(clk), .rstn_i(rstn), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .ext_edge_pin_i(pin), .timer0_ovf_i(t0),
    .pin_change_flags_i(pcf), .periph_flags_i(pf), .pc_i(pc),
    .live_ctx_i(live), .return_from_handler_i(ret), .irq_enter_o(enter),
    .push_pc_o(push_pc), .vector_pc_o(vec), .handler_exit_o(hx),
    .restore_ctx_o(rest), .in_handler_o(in_h));

  core_seq_model u_core (
    .clk_i(clk), .rstn_i(rstn), .enter_i(enter), .exit_i(hx),
    .restore_ctx_i(rest), .delay_i(dly), .pc_o(pc), .live_ctx_o(live),
    .ret_o(ret));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic summarize();
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic hang();
    num_errors++;
    summarize();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      ha = awready;
      hw = wready;
      hb = bvalid;
      resp = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      ha = arready;
      hr = rvalid;
      q = rdata;
      resp = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
      if (hr) begin
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  // which: 0 waits for entry, 1 for handler exit
  task automatic wait_on(input bit which);
    for (lat = 1; lat < 100; lat++) begin
      @(negedge clk);
      if (which ? hx : enter) return;
    end
    hang();
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
  endtask

  initial begin
    do_reset();
    @(negedge clk);
    `CHK(vec, 15'h0004)
    `CHK(in_h, 1'b0)
    rd(`OFS_CONTROL);
    `CHK(q, 32'h0)
    rd(`OFS_PERIPH_EN);
    `CHK(q, 32'h0)
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      `CHK(resp, rows[i].r)
      rd(rows[i].a);
      `CHK(q, rows[i].q)
      `CHK(resp, rows[i].r)
    end
    foreach (edges[i]) begin
      wr(`OFS_EDGE_SEL, {31'h0, edges[i][2]});
      wr(`OFS_CONTROL, 32'h0);
      pin <= edges[i][1];
      repeat (8) @(posedge clk);
      rd(`OFS_CONTROL);
      `CHK(q[7:0], {6'h0, edges[i][0], 1'b0})
    end
    @(posedge clk);
    t0 <= 1'b1;
    @(posedge clk);
    t0 <= 1'b0;
    pcf <= 8'h10;
    repeat (3) @(posedge clk);
    rd(`OFS_CONTROL);
    `CHK(q, 32'h07)
    wr(`OFS_CONTROL, 32'h0);
    pcf <= 8'h00;
    repeat (3) @(posedge clk);
    // summary bit must ignore the write
    wr(`OFS_CONTROL, 32'h01);
    rd(`OFS_CONTROL);
    `CHK(q, 32'h0)
    wr(`OFS_EDGE_SEL, 32'h1);
    wr(`OFS_CONTROL, 32'h90);
    pin <= 1'b1;
    wait_on(1'b0);
    `CHK(lat >= 12 && lat <= 20, 1'b1)
    `CHK(push_pc, 15'h0123)
    `CHK(in_h, 1'b1)
    rd(`OFS_CONTROL);
    `CHK(q, 32'h12)
    rd(`OFS_SHADOW_BASE);
    `CHK(q, 32'h11)
    rd(`OFS_SHADOW_BASE + 8'h04);
    `CHK(q, 32'h07)
    rd(`OFS_SHADOW_LAST);
    `CHK(q, 32'h88)
    wr(`OFS_CONTROL, 32'h10);
    wr(`OFS_SHADOW_BASE, 32'h77);
    wait_on(1'b1);
    `CHK({rest.acc, rest.status[2:0]}, {8'h77, 3'h7})
    `CHK(rest[47:0], 48'h3344_5566_7788)
    `CHK(in_h, 1'b0)
    rd(`OFS_CONTROL);
    `CHK(q, 32'h90)
    dly <= 8'h06;
    wr(`OFS_PERIPH_EN, 32'h01);
    pf <= 8'h01;
    foreach (ctl[i]) begin
      wr(`OFS_CONTROL, ctl[i]);
      seen = 8'h00;
      repeat (30) begin
        @(negedge clk);
        seen += enter;
      end
      `CHK(seen, 8'h00)
    end
    wr(`OFS_CONTROL, 32'hc0);
    wait_on(1'b0);
    @(posedge clk);
    pf <= 8'h00;
    wait_on(1'b1);
    `CHK(rest.acc, 8'h77)
    @(posedge clk);
    pf <= 8'h01;
    wait_on(1'b0);
    do_reset();
    pf <= 8'h00;
    @(negedge clk);
    `CHK(in_h, 1'b0)
    rd(`OFS_CONTROL);
    `CHK(q, 32'h0)
    summarize();
  end
endmodule
